// *** hw/csp_top.sv ***
// status byte reports and conditional units behind an AXI4-Lite slave
// assumes sources on sys_clk and one outstanding read and write
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"

// Function
// R1: each report builds one byte from eight selectable status bits
// R2: each source entry picks its bit slot, first to eighth
// R3: slots with no source read zero
// R4: report one holds inputs 1-8; report two inputs 7-10, outputs 1-4
// R5: report three holds outputs 5-8; slots 5-8 empty and zero
// R6: each conditional unit yields one bit, true or false
// R7: two conditions each compare a pair of logical or integer inputs
// R8: a third operator merges both conditions into the unit result
// R9: inputs come from source type and index; none selected gives zero
// R10: after reset the four inputs are digital inputs one to four
// R11: codes 0, 1, 2 are equal, not equal, greater
// R12: codes 3, 4, 5 are greater-or-equal, less, less-or-equal
// R13: code 6 is logical OR, code 7 logical AND
// R14: merge codes 0 OR, 1 AND, 2 XOR
// R15: both comparison operators reset to AND
// R16: the merging operator has no relational codes
// R17: with one condition in use, software sets merge to OR
// R18: transmit fields carrying a report should be at least a byte
// R19: logical operators treat nonzero integers as true
// R20: all results are evaluated and registered every cycle
module csp_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [`CSP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data and response
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [`CSP_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sources from the input, output and receive blocks
  input wire logic [`CSP_NUM_DIN-1:0] digitalIn,
  input wire logic [`CSP_NUM_DOUT-1:0] digitalOut,
  input wire csp_pkg::csp_rx_type rxValue,
  // results
  output logic [`CSP_NUM_RPT-1:0][7:0] statusByteReport,
  output logic [`CSP_NUM_COND-1:0] condResult
);
  import csp_pkg::*;

  // which register group a bus address falls into
  typedef enum logic [1:0] {
    CSP_REG_ENTRY, CSP_REG_COND, CSP_REG_STATUS, CSP_REG_NONE
  } csp_reg_type;

  // decoded address: group and word index
  typedef struct packed {
    csp_reg_type kind;
    logic [4:0] idx;
  } csp_dec_type;

  typedef struct packed {
    // configuration, the only state software writes
    csp_entry_arr_type entries;
    csp_cond_type [`CSP_NUM_COND-1:0] cond;

    // write capture
    logic [`CSP_ADDR_W-1:0] awAddr;
    logic awGot;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wGot;

    // handshake outputs, one flop each, two for bResp
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;

    // read channel
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } csp_top_state_type;

  // constant reset image, built once at elaboration
  function automatic csp_top_state_type csp_reset_state();
    csp_top_state_type r;
    int i;
    r = '0;
    for (int rp = 0; rp < `CSP_NUM_RPT; rp++) begin
      for (int e = 0; e < `CSP_NUM_ENT; e++) begin
        i = rp * `CSP_NUM_ENT + e;
        r.entries[i].slot = 3'(e); // see R2
        if (rp == 0) begin
          r.entries[i].sel.src = CSP_SRC_DIN; // see R4
          r.entries[i].sel.index = 4'(e);
        end else if (rp == 1 && e < `CSP_DEF_SPLIT) begin
          r.entries[i].sel.src = CSP_SRC_DIN; // see R4
          r.entries[i].sel.index = 4'(e + `CSP_DEF_R1_DIN);
        end else if (rp == 1) begin
          r.entries[i].sel.src = CSP_SRC_DOUT; // see R4
          r.entries[i].sel.index = 4'(e - `CSP_DEF_SPLIT);
        end else if (e < `CSP_DEF_SPLIT) begin
          r.entries[i].sel.src = CSP_SRC_DOUT; // see R5
          r.entries[i].sel.index = 4'(e + `CSP_DEF_R2_DOUT);
        end else begin
          r.entries[i].sel.src = CSP_SRC_NONE; // see R5
        end
      end
    end
    // units: inputs 1 to 4, both operators AND
    for (int c = 0; c < `CSP_NUM_COND; c++) begin
      for (int k = 0; k < `CSP_NUM_CIN; k++) begin
        r.cond[c].in[k].src = CSP_SRC_DIN; // see R10
        r.cond[c].in[k].index = 4'(k);
      end
      r.cond[c].op1 = `CSP_OP_AND; // see R15
      r.cond[c].op2 = `CSP_OP_AND; // see R15
      r.cond[c].merge = `CSP_MRG_OR;
    end
    // readies idle high so a first request is taken at once
    r.awReady = 1'b1;
    r.wReady = 1'b1;
    r.arReady = 1'b1;
    return r;
  endfunction : csp_reset_state

  // a constant image keeps the reset branch free of logic
  localparam csp_top_state_type CSP_RST_STATE = csp_reset_state();

  // address decoding shared by the write and read paths
  function automatic csp_dec_type csp_decode(
      logic [`CSP_ADDR_W-1:0] addr);
    csp_dec_type d;
    d.kind = CSP_REG_NONE;
    d.idx = '0;
    // status word is read-only; writes to it are refused
    if (addr < `CSP_ADDR_COND) begin
      d.kind = CSP_REG_ENTRY;
      d.idx = addr[6:2];
    end else if (addr < `CSP_ADDR_COND_END) begin
      d.kind = CSP_REG_COND;
      d.idx = {4'h0, addr[2]};
    end else if (addr[7:2] == `CSP_ADDR_STATUS >> 2) begin
      d.kind = CSP_REG_STATUS;
    end
    return d;
  endfunction : csp_decode

  // unstrobed byte lanes keep their old contents
  function automatic logic [31:0] csp_strobe(logic [31:0] old,
      logic [31:0] data, logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return m;
  endfunction : csp_strobe

  csp_top_state_type s_reg;
  csp_top_state_type s_next;

  // one source bundle feeds every packer and unit
  csp_src_if srcBus();

  assign srcBus.din = digitalIn;
  assign srcBus.dout = digitalOut;
  assign srcBus.rx = rxValue;

  // report packers first, then the conditional units
  genvar gr;
  generate
    for (gr = 0; gr < `CSP_NUM_RPT; gr++) begin : g_report
      csp_status_packer u_packer (
        .sys_clk(sys_clk),
        .rst(rst),
        .srcBus(srcBus),
        .entry(s_reg.entries[gr*`CSP_NUM_ENT +: `CSP_NUM_ENT]),
        .statusByte(statusByteReport[gr])
      ); // see R1
    end
    for (gr = 0; gr < `CSP_NUM_COND; gr++) begin : g_cond
      csp_cond_unit u_cond (
        .sys_clk(sys_clk),
        .rst(rst),
        .srcBus(srcBus),
        .cfg(s_reg.cond[gr]),
        .result(condResult[gr])
      ); // see R6
    end
  endgenerate

  always_comb begin
    csp_dec_type wd;
    csp_dec_type rd;
    logic [31:0] merged;
    wd = csp_decode(s_reg.awAddr);
    rd = csp_decode(s_axi_araddr);
    merged = '0;
    s_next = s_reg;

    // address and data are taken independently, in either order
    if (s_reg.awReady && s_axi_awvalid) begin
      s_next.awAddr = s_axi_awaddr;
      s_next.awGot = 1'b1;
    end
    if (s_reg.wReady && s_axi_wvalid) begin
      s_next.wData = s_axi_wdata;
      s_next.wStrb = s_axi_wstrb;
      s_next.wGot = 1'b1;
    end

    // commit once both halves are in; the response follows
    if (s_reg.awGot && s_reg.wGot) begin
      s_next.awGot = 1'b0;
      s_next.wGot = 1'b0;
      s_next.bValid = 1'b1;
      s_next.bResp = `CSP_RESP_OKAY;
      unique case (wd.kind)
        CSP_REG_ENTRY: begin
          merged = csp_strobe(32'(s_reg.entries[wd.idx]),
                              s_reg.wData, s_reg.wStrb);
          s_next.entries[wd.idx] =
              csp_entry_type'(merged[$bits(csp_entry_type)-1:0]);
        end
        CSP_REG_COND: begin
          // merge code 3 is stored but evaluates false
          merged = csp_strobe(32'(s_reg.cond[wd.idx[0]]),
                              s_reg.wData, s_reg.wStrb);
          s_next.cond[wd.idx[0]] =
              csp_cond_type'(merged[$bits(csp_cond_type)-1:0]);
        end
        CSP_REG_STATUS: s_next.bResp = `CSP_RESP_SLVERR;
        CSP_REG_NONE: s_next.bResp = `CSP_RESP_SLVERR;
      endcase
    end
    // response leaves on its handshake only
    if (s_reg.bValid && s_axi_bready) begin
      s_next.bValid = 1'b0;
    end
    // no new write is taken until the response has gone
    s_next.awReady = !s_next.awGot && !s_next.bValid;
    s_next.wReady = !s_next.wGot && !s_next.bValid;

    // reads answer at once; data stands until rready
    if (s_reg.arReady && s_axi_arvalid) begin
      s_next.rValid = 1'b1;
      s_next.rResp = `CSP_RESP_OKAY;
      s_next.rData = '0;
      unique case (rd.kind)
        CSP_REG_ENTRY: s_next.rData = 32'(s_reg.entries[rd.idx]);
        CSP_REG_COND: s_next.rData = 32'(s_reg.cond[rd.idx[0]]);
        CSP_REG_STATUS: s_next.rData = 32'({condResult, statusByteReport});
        CSP_REG_NONE: s_next.rResp = `CSP_RESP_SLVERR;
      endcase
    end else if (s_reg.rValid && s_axi_rready) begin
      s_next.rValid = 1'b0;
    end
    // one read outstanding: no address while data waits
    s_next.arReady = !s_next.rValid;
  end

  // one register stage for bus and configuration state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_reg <= CSP_RST_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  // bus outputs come straight from the state register
  assign s_axi_awready = s_reg.awReady;
  assign s_axi_wready = s_reg.wReady;
  assign s_axi_bvalid = s_reg.bValid;
  assign s_axi_bresp = s_reg.bResp;
  assign s_axi_arready = s_reg.arReady;
  assign s_axi_rvalid = s_reg.rValid;
  assign s_axi_rdata = s_reg.rData;
  assign s_axi_rresp = s_reg.rResp;

endmodule : csp_top

`default_nettype wire

// *** hw/csp_defs.svh ***
// constants of the status packer and conditional units
// assumes inclusion by csp_pkg, the design files and the sim files
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH

// source counts and widths
`define CSP_NUM_DIN 10
`define CSP_NUM_DOUT 8
`define CSP_NUM_RX 16
`define CSP_VAL_W 32
`define CSP_NUM_RPT 3
`define CSP_NUM_ENT 8
`define CSP_NUM_COND 2
`define CSP_NUM_CIN 4

// input comparison operator codes
`define CSP_OP_EQ 3'h0
`define CSP_OP_NE 3'h1
`define CSP_OP_GT 3'h2
`define CSP_OP_GE 3'h3
`define CSP_OP_LT 3'h4
`define CSP_OP_LE 3'h5
`define CSP_OP_OR 3'h6
`define CSP_OP_AND 3'h7

// condition merging operator codes
`define CSP_MRG_OR 2'h0
`define CSP_MRG_AND 2'h1
`define CSP_MRG_XOR 2'h2

// default source layout of the reports
`define CSP_DEF_SPLIT 4
`define CSP_DEF_R1_DIN 6
`define CSP_DEF_R2_DOUT 4

// register map, byte addresses
`define CSP_ADDR_W 8
`define CSP_ADDR_COND 8'h60
`define CSP_ADDR_COND_END 8'h68
`define CSP_ADDR_STATUS 8'h70
`define CSP_RESP_OKAY 2'h0
`define CSP_RESP_SLVERR 2'h2

`endif

// *** hw/csp_pkg.sv ***
// types and shared decoding of the status packer
// assumes csp_defs.svh on the include path
`include "csp_defs.svh"

package csp_pkg;

  typedef enum logic [1:0] {
    CSP_SRC_NONE, CSP_SRC_DIN, CSP_SRC_DOUT, CSP_SRC_RX
  } csp_src_type;

  typedef struct packed {
    logic [3:0] index;
    csp_src_type src;
  } csp_sel_type;

  typedef struct packed {
    logic [2:0] slot;
    csp_sel_type sel;
  } csp_entry_type;

  typedef struct packed {
    logic [1:0] merge;
    logic [2:0] op2;
    logic [2:0] op1;
    csp_sel_type [`CSP_NUM_CIN-1:0] in;
  } csp_cond_type;

  typedef logic [`CSP_NUM_RX-1:0][`CSP_VAL_W-1:0] csp_rx_type;
  typedef csp_entry_type [`CSP_NUM_RPT*`CSP_NUM_ENT-1:0] csp_entry_arr_type;

  // out-of-range indices read as zero, like an unselected source
  function automatic logic [`CSP_VAL_W-1:0] csp_select(
      csp_sel_type sel, logic [`CSP_NUM_DIN-1:0] din,
      logic [`CSP_NUM_DOUT-1:0] dout, csp_rx_type rx);
    logic [`CSP_VAL_W-1:0] v;
    v = '0;
    unique case (sel.src)
      CSP_SRC_NONE: v = '0;
      CSP_SRC_DIN: if (sel.index < 4'(`CSP_NUM_DIN))
        v = `CSP_VAL_W'(din[sel.index]);
      CSP_SRC_DOUT: if (sel.index < 4'(`CSP_NUM_DOUT))
        v = `CSP_VAL_W'(dout[sel.index[2:0]]);
      CSP_SRC_RX: v = rx[sel.index];
    endcase
    return v;
  endfunction : csp_select

endpackage : csp_pkg

// *** hw/csp_src_if.sv ***
// source values shared by the packers and conditional units
// assumes csp_pkg compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"

interface csp_src_if;
  logic [`CSP_NUM_DIN-1:0] din;
  logic [`CSP_NUM_DOUT-1:0] dout;
  csp_pkg::csp_rx_type rx;
  modport src(output din, output dout, output rx);
  modport sink(input din, input dout, input rx);
endinterface : csp_src_if

`default_nettype wire

// *** hw/csp_status_packer.sv ***
// one status byte report: eight selectable bits packed into a byte
// assumes configuration held stable by the register block
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"

module csp_status_packer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // sources and configuration
  csp_src_if.sink srcBus,
  input wire csp_pkg::csp_entry_type [`CSP_NUM_ENT-1:0] entry,
  // packed byte
  output logic [7:0] statusByte
);
  import csp_pkg::*;

  typedef struct packed {
    logic [7:0] byteOut;
  } csp_pack_state_type;

  csp_pack_state_type s_reg;
  csp_pack_state_type s_next;

  always_comb begin
    s_next.byteOut = '0; // see R3
    for (int e = 0; e < `CSP_NUM_ENT; e++) begin // see R1
      if (entry[e].sel.src != CSP_SRC_NONE) begin
        // integer sources count as set when nonzero
        s_next.byteOut[entry[e].slot] = s_next.byteOut[entry[e].slot] |
            (csp_select(entry[e].sel, srcBus.din, srcBus.dout,
                        srcBus.rx) != '0); // see R2 see R19
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next; // see R20
    end
  end

  assign statusByte = s_reg.byteOut;

endmodule : csp_status_packer

`default_nettype wire

// *** hw/csp_cond_unit.sv ***
// one conditional unit: two compared pairs merged into one bit
// assumes configuration held stable by the register block
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"

module csp_cond_unit (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // sources and configuration
  csp_src_if.sink srcBus,
  input wire csp_pkg::csp_cond_type cfg,
  // result
  output logic result
);
  import csp_pkg::*;

  typedef struct packed {
    logic res;
  } csp_cond_state_type;

  csp_cond_state_type s_reg;
  csp_cond_state_type s_next;

  // unsigned compare; logical codes take nonzero as true
  function automatic logic csp_compare(logic [2:0] op,
      logic [`CSP_VAL_W-1:0] a, logic [`CSP_VAL_W-1:0] b);
    logic r;
    r = 1'b0;
    unique case (op)
      `CSP_OP_EQ: r = (a == b); // see R11
      `CSP_OP_NE: r = (a != b); // see R11
      `CSP_OP_GT: r = (a > b); // see R11
      `CSP_OP_GE: r = (a >= b); // see R12
      `CSP_OP_LT: r = (a < b); // see R12
      `CSP_OP_LE: r = (a <= b); // see R12
      `CSP_OP_OR: r = (a != '0) || (b != '0); // see R13 see R19
      `CSP_OP_AND: r = (a != '0) && (b != '0); // see R13 see R19
    endcase
    return r;
  endfunction : csp_compare

  always_comb begin
    logic [`CSP_NUM_CIN-1:0][`CSP_VAL_W-1:0] v;
    logic c1;
    logic c2;
    v = '0;
    c1 = 1'b0;
    c2 = 1'b0;
    for (int k = 0; k < `CSP_NUM_CIN; k++) begin
      v[k] = csp_select(cfg.in[k], srcBus.din, srcBus.dout,
                        srcBus.rx); // see R9
    end
    c1 = csp_compare(cfg.op1, v[0], v[1]); // see R7
    c2 = csp_compare(cfg.op2, v[2], v[3]); // see R7
    // unused code 3 gives false rather than a relational result
    case (cfg.merge) // see R16
      `CSP_MRG_OR: s_next.res = c1 | c2; // see R14 see R8
      `CSP_MRG_AND: s_next.res = c1 & c2; // see R14
      `CSP_MRG_XOR: s_next.res = c1 ^ c2; // see R14
      default: s_next.res = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next; // see R6 see R20
    end
  end

  assign result = s_reg.res;

endmodule : csp_cond_unit

`default_nettype wire

// *** sim/csp_top_sva.sv ***
// checker of the status packer top ports
// assumes bind onto csp_top, one sys_clk domain
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"
module csp_top_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sources and results
  input wire logic [`CSP_NUM_DIN-1:0] digitalIn,
  input wire logic [`CSP_NUM_DOUT-1:0] digitalOut,
  input wire logic [`CSP_NUM_RPT-1:0][7:0] statusByteReport,
  input wire logic [`CSP_NUM_COND-1:0] condResult
);
  // defaults only hold until software first writes a register
  logic touchedReg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      touchedReg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      touchedReg <= 1'b1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_dflt_rpt_one:
  assert property (!touchedReg && !$past(rst) |->
    statusByteReport[0] == $past(digitalIn[7:0]))
    else $error("report one differs from inputs");
  chk_dflt_rpt_two:
  assert property (!touchedReg && !$past(rst) |-> statusByteReport[1] ==
    {$past(digitalOut[3:0]), $past(digitalIn[9:6])})
    else $error("report two differs from sources");
  chk_dflt_rpt_three:
  assert property (!touchedReg && !$past(rst) |->
    statusByteReport[2] == {4'h0, $past(digitalOut[7:4])})
    else $error("report three differs from outputs");
  chk_dflt_cond_and:
  assert property (!touchedReg && !$past(rst) |-> condResult == {2{
    ($past(digitalIn[0]) & $past(digitalIn[1])) |
    ($past(digitalIn[2]) & $past(digitalIn[3]))}})
    else $error("default conditional result wrong");
  chk_b_refuse:
  assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_b_stands:
  assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_stands:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed while waiting");
  chk_r_done:
  assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cov_cond_rise: cover property ($rose(condResult[0]));
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : csp_top_sva
bind csp_top csp_top_sva chk (.sys_clk(sys_clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .digitalIn(digitalIn), .digitalOut(digitalOut),
  .statusByteReport(statusByteReport), .condResult(condResult));
`default_nettype wire

// *** sim/csp_tx_model.sv ***
// far side: a transmit block latching the packed reports and results
// assumes it shares sys_clk with csp_top
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"
module csp_tx_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // report bytes and conditional results
  input wire logic [`CSP_NUM_RPT-1:0][7:0] statusByte,
  input wire logic [`CSP_NUM_COND-1:0] condBit,
  // payload as the transmitter would send it
  output logic [25:0] txFrame
);
  // each report gets a whole byte field so no packed bit is lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txFrame <= '0;
    end else begin
      txFrame <= {condBit, statusByte};
    end
  end
endmodule : csp_tx_model
`default_nettype wire

// *** sim/tb_condition_and_status_packer.sv ***
// self-checking bench of the status packer and conditional units
// assumes csp_top, csp_tx_model and csp_defs.svh are available
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"
module tb_condition_and_status_packer;
  logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, cfg0, cfg1;
  logic [1:0] s_axi_bresp, s_axi_rresp, condResult;
  logic [`CSP_NUM_DIN-1:0] digitalIn;
  logic [7:0] digitalOut;
  csp_pkg::csp_rx_type rxValue;
  logic [2:0][7:0] statusByteReport;
  logic [25:0] txFrame;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [9:0] dPat [3] = '{10'h15a, 10'h0fc, 10'h3f3};
  logic [7:0] oPat [3] = '{8'h3c, 8'hc3, 8'ha5};
  logic [31:0] pa [5] = '{3, 5, 7, 0, 0};
  logic [31:0] pb [5] = '{5, 5, 5, 9, 0};

  csp_top dut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .digitalIn(digitalIn), .digitalOut(digitalOut), .rxValue(rxValue),
    .statusByteReport(statusByteReport), .condResult(condResult));
  csp_tx_model txModel (.sys_clk(sys_clk), .rst(rst),
    .statusByte(statusByteReport), .condBit(condResult),
    .txFrame(txFrame));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic check(input string nm, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge sys_clk);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(er), 32'(s_axi_bresp));
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
    check("rdata", d, s_axi_rdata);
    check("rresp", 32'(er), 32'(s_axi_rresp));
  endtask : axi_read

  // mapped: report one bit-reversed, report three emptied
  function automatic logic [23:0] rpt(input logic m);
    logic [7:0] r0;
    for (int k = 0; k < 8; k++) r0[k] = m ? digitalIn[7-k] : digitalIn[k];
    return {m ? 8'h00 : {4'h0, digitalOut[7:4]}, digitalOut[3:0],
      digitalIn[9:6], r0};
  endfunction : rpt

  task automatic pat(input logic [9:0] d, input logic [7:0] o,
      input logic m);
    logic [1:0] c;
    digitalIn <= d;
    digitalOut <= o;
    repeat (3) @(posedge sys_clk);
    c = {2{(d[0] & d[1]) | (d[2] & d[3])}};
    check("reports", 32'(rpt(m)), 32'(statusByteReport));
    check("results", 32'(c), 32'(condResult));
    check("frame", 32'({c, rpt(m)}), 32'(txFrame));
    axi_read(8'h70, 32'({c, rpt(m)}), 2'h0);
  endtask : pat

  function automatic logic f_op(input logic [2:0] op, input logic [31:0] a, b);
    case (op)
      3'h0: return a == b;
      3'h1: return a != b;
      3'h2: return a > b;
      3'h3: return a >= b;
      3'h4: return a < b;
      3'h5: return a <= b;
      3'h6: return (a != 0) || (b != 0);
      default: return (a != 0) && (b != 0);
    endcase
  endfunction : f_op

  function automatic logic res(input logic [31:0] c, a, b, x);
    logic p, q;
    p = f_op(c[26:24], a, b);
    q = f_op(c[29:27], x, 32'h0);
    case (c[31:30])
      2'h0: return p | q;
      2'h1: return p & q;
      2'h2: return p ^ q;
      default: return 1'b0;
    endcase
  endfunction : res

  // inputs 1-3 from received values 0-2, input 4 unselected
  function automatic logic [31:0] cw(input logic [2:0] o1, o2,
      input logic [1:0] m);
    return {m, o2, o1, 6'h00, 6'h0b, 6'h07, 6'h03};
  endfunction : cw

  task automatic cfg(input logic [31:0] w0, w1);
    cfg0 = w0;
    cfg1 = w1;
    axi_write(8'h60, w0, 2'h0);
    axi_write(8'h64, w1, 2'h0);
  endtask : cfg

  task automatic cond_chk(input logic [31:0] a, b, x);
    rxValue[0] <= a;
    rxValue[1] <= b;
    rxValue[2] <= x;
    repeat (3) @(posedge sys_clk);
    check("cond", 32'({res(cfg1, a, b, x), res(cfg0, a, b, x)}),
      32'(condResult));
  endtask : cond_chk

  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    digitalIn = '0;
    digitalOut = '0;
    rxValue = '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    axi_read(8'h60, 32'h3f349141, 2'h0);
    axi_read(8'h00, 32'h1, 2'h0);
    axi_read(8'h30, 32'h102, 2'h0);
    axi_read(8'h50, 32'h100, 2'h0);
    for (int i = 0; i < 3; i++) pat(dPat[i], oPat[i], 1'b0);
    axi_read(8'h68, 32'h0, 2'h2);
    axi_write(8'h68, 32'hffffffff, 2'h2);
    axi_write(8'h70, 32'h0, 2'h2);
    pat(10'h2a5, 8'h5a, 1'b0);
    for (int e = 0; e < 8; e++) begin
      axi_write(8'(e * 4), 32'({3'(7 - e), 4'(e), 2'h1}), 2'h0);
      axi_write(8'(64 + e * 4), 32'h0, 2'h0);
    end
    axi_read(8'h04, 32'h185, 2'h0);
    for (int i = 0; i < 3; i++) pat(dPat[i], oPat[i], 1'b1);
    for (int op = 0; op < 8; op++) begin
      cfg(cw(3'(op), 3'h0, 2'h0), cw(3'(7 - op), 3'h0, 2'h0));
      for (int p = 0; p < 5; p++) begin
        cond_chk(pa[p], pb[p], 32'h5);
      end
    end
    for (int m = 0; m < 4; m++) begin
      cfg(cw(3'h0, 3'h1, 2'(m)), cw(3'h0, 3'h1, 2'(m + 1)));
      for (int c = 0; c < 4; c++) begin
        cond_chk(0, c[0] ? 0 : 1, c[1] ? 5 : 0);
      end
    end
    end_of_test();
  end
endmodule : tb_condition_and_status_packer
`default_nettype wire
